/* inc/ucsb_pkg.sv */
// constants for the serial control/status/baud block
// assumes a 32-bit avalon-mm slave with byte addresses, word-aligned registers
`default_nettype none
package ucsb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_BAUD     = 6'h09;
    localparam logic [5:0] IDX_CTRL     = 6'h0A;
    localparam logic [5:0] IDX_STAT     = 6'h0B;
    localparam logic [5:0] IDX_DATA     = 6'h0C;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
    // control fields
    localparam int CTL_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
    localparam int CTL_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
    localparam int CTL_BUFFER_EMPTY_IRQ_ENABLE = 5;
    localparam int CTL_RECEIVER_ENABLE  = 4;
    localparam int CTL_TRANSMITTER_ENABLE  = 3;
    localparam int CTL_NINE_BIT_CHARACTER_MODE  = 2;
    localparam int CTL_RECEIVED_NINTH_BIT  = 1;
    localparam int CTL_TRANSMIT_NINTH_BIT  = 0;
    // status fields
    localparam int ST_RXC  = 7;
    localparam int ST_TXC  = 6;
    localparam int ST_TRANSMIT_BUFFER_EMPTY_FLAG = 5;
    localparam int ST_FE   = 4;
    localparam int ST_OR   = 3;
    // irq status/mask fields
    localparam int IRQ_RX   = 0;
    localparam int IRQ_TX   = 1;
    localparam int IRQ_BUFE = 2;
    localparam int IRQ_GIE  = 7;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h02;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // sixteen-times oversampling
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID  = 4'h7;
    localparam logic [3:0] LAST8     = 4'h7;
    localparam logic [3:0] LAST9     = 4'h8;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } ucsb_rx_state_t;
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } ucsb_tx_state_t;
endpackage
`default_nettype wire

/* rtl/ucsb_baud.sv */
// sixteen-times bit-rate tick generator
// assumes the divisor is a registered value on the same clock
`default_nettype none
module ucsb_baud #(
    parameter int DIV_W = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [DIV_W-1:0] divisor,
    output var  logic             tick
);
    logic [DIV_W-1:0] cnt;
    wire              cnt_zero = (cnt == '0);

    // one tick every divisor+1 clocks gives clk/(16*(divisor+1)) baud
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= cnt_zero ? divisor : cnt - 1'b1;
            tick <= cnt_zero;
        end
    end

    // divisor zero ticks on every clock, so only a reload from a nonzero divisor must leave a gap
    property p_tick_one;
        cnt_zero && (divisor != '0) |=> tick ##1 !tick;
    endproperty
    a_tick_one: assert property (@(posedge sys_clk) disable iff (sys_rst) p_tick_one)
        else $error("baud tick longer than one cycle");
endmodule
`default_nettype wire

/* rtl/ucsb_top.sv */
// serial transmitter/receiver with control, status and baud divisor registers
// assumes an avalon-mm master on sys_clk and an asynchronous remote on the line
// Operation
// - stop bit sampled as one clears the framing error flag.
// - new character finished while data register unread is an overrun.
// - overrun flag shows only when software reads the held character.
// - character loaded without overrun clears the overrun flag.
// - status bits two to zero always read as zero.
// - receive-complete irq requested when enabled and flag sets.
// - transmit-complete irq requested when enabled and flag sets.
// - buffer-empty irq requested when enabled and flag sets.
// - receiver runs only when enabled; its flags cannot set otherwise (or_flag still sets on a data read after an earlier overrun).
// - disabling the receiver leaves its set flags untouched.
// - transmitter is switched on by setting transmitter enable bit three to one.
// - disabled transmitter still finishes shift and pending buffer characters.
// - nine-bit mode frames nine data bits with start and stop.
// - ninth received bit readable, ninth transmit bit write-only.
// - baud divisor is an eight-bit read/write register.
// - divisor values give the tabulated bit rates.
//
// Register access over Avalon-MM was decided locally.
`default_nettype none
module ucsb_top
    import ucsb_pkg::*;
(
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic [ucsb_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [ucsb_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output var  logic [ucsb_pkg::DATA_W-1:0]   avs_readdata,
    output var  logic                          avs_waitrequest,
    input  wire logic                          rx_in,
    output var  logic                          tx_out,
    output var  logic                          irq
);
    // registers
    logic [7:0]     ctrl;
    logic [7:0]     baud_div;
    logic [7:0]     irq_stat;
    logic [7:0]     irq_mask;
    logic           rx_meta;
    logic           rx_sync;
    logic           tick16;
    ucsb_rx_state_t rx_st;
    logic [3:0]     rx_scnt;
    logic [3:0]     rx_bcnt;
    logic [8:0]     rx_sh;
    logic [7:0]     rx_data;
    logic           rx_ninth;
    logic           receive_complete_flag;
    logic           fe;
    logic           or_flag;
    logic           ovr_pend;
    ucsb_tx_state_t tx_st;
    logic [3:0]     tx_scnt;
    logic [3:0]     tx_bcnt;
    logic [8:0]     tx_sh;
    logic [8:0]     tx_buf;
    logic           buf_full;
    logic           transmit_complete_flag;
    logic           tx_active;

    // bus decode
    wire [5:0] idx     = avs_address[7:2];
    wire       acc     = (avs_read | avs_write) & ~avs_waitrequest;
    wire       wr_lo   = acc & avs_write & avs_byteenable[0];
    wire       rd_acc  = acc & avs_read;
    wire [7:0] wb      = avs_writedata[7:0];
    wire       wr_ctrl = wr_lo & (idx == IDX_CTRL);
    wire       wr_baud = wr_lo & (idx == IDX_BAUD);
    wire       wr_stat = wr_lo & (idx == IDX_STAT);
    wire       wr_data = wr_lo & (idx == IDX_DATA);
    wire       wr_ist  = wr_lo & (idx == IDX_IRQ_STAT);
    wire       wr_imsk = wr_lo & (idx == IDX_IRQ_MASK);
    wire       data_rd = rd_acc & (idx == IDX_DATA);

    wire rx_en = ctrl[CTL_RECEIVER_ENABLE];
    wire tx_en = ctrl[CTL_TRANSMITTER_ENABLE];
    wire nine  = ctrl[CTL_NINE_BIT_CHARACTER_MODE];
    wire [3:0] last_bit = nine ? LAST9 : LAST8;

    // status view; low three bits are constant zero
    wire [7:0] stat_view = {receive_complete_flag, transmit_complete_flag, ~buf_full, fe, or_flag, 3'b000};
    wire [7:0] ctrl_view = {ctrl[7:2], rx_ninth, 1'b0};

    wire [7:0] rd_mux = (idx == IDX_CTRL)     ? ctrl_view :
                        (idx == IDX_BAUD)     ? baud_div  :
                        (idx == IDX_STAT)     ? stat_view :
                        (idx == IDX_DATA)     ? rx_data   :
                        (idx == IDX_IRQ_STAT) ? irq_stat  :
                        (idx == IDX_IRQ_MASK) ? irq_mask  : 8'h00;

    // one wait cycle per access; read data is captured while the request waits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            avs_readdata    <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl     <= CTRL_RST;
            baud_div <= BAUD_RST;
            irq_mask <= MASK_RST;
        end else begin
            if (wr_ctrl) ctrl <= {wb[7:2], 1'b0, wb[0]};
            if (wr_baud) baud_div <= wb;
            if (wr_imsk) irq_mask <= wb;
        end
    end

    // line input is asynchronous: two flops before any use
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_in;
            rx_sync <= rx_meta;
        end
    end

    ucsb_baud #(
        .DIV_W (8)
    ) u_baud (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .divisor (baud_div),
        .tick    (tick16)
    );

    // receiver
    wire rx_done = rx_en & tick16 & (rx_st == RX_STOP) & (rx_scnt == TICK_LAST);
    wire rx_busy = receive_complete_flag & ~data_rd;
    wire rx_load = rx_done & ~rx_busy;
    wire rx_ovr  = rx_done & rx_busy;

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !rx_en) begin
            rx_st   <= RX_IDLE;
            rx_scnt <= 4'h0;
            rx_bcnt <= 4'h0;
            rx_sh   <= 9'h000;
        end else begin
            unique case (rx_st)
                RX_IDLE: begin
                    rx_scnt <= 4'h0;
                    if (!rx_sync) rx_st <= RX_START;
                end
                RX_START: if (tick16) begin
                    rx_scnt <= rx_scnt + 1'b1;
                    if (rx_scnt == TICK_MID) begin
                        rx_scnt <= 4'h0;
                        rx_bcnt <= 4'h0;
                        rx_st   <= rx_sync ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: if (tick16) begin
                    rx_scnt <= rx_scnt + 1'b1;
                    if (rx_scnt == TICK_LAST) begin
                        rx_sh   <= {rx_sync, rx_sh[8:1]};
                        rx_bcnt <= rx_bcnt + 1'b1;
                        if (rx_bcnt == last_bit) rx_st <= RX_STOP;
                    end
                end
                RX_STOP: if (tick16) begin
                    rx_scnt <= rx_scnt + 1'b1;
                    if (rx_scnt == TICK_LAST) rx_st <= RX_IDLE;
                end
            endcase
        end
    end

    // receive flags; disabling the receiver does not touch them
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_data  <= 8'h00;
            rx_ninth <= CTRL_RST[CTL_RECEIVED_NINTH_BIT];
            receive_complete_flag      <= 1'b0;
            fe       <= 1'b0;
            or_flag  <= 1'b0;
            ovr_pend <= 1'b0;
        end else begin
            if (data_rd) begin
                receive_complete_flag <= 1'b0;
                if (ovr_pend) begin
                    or_flag  <= 1'b1;
                    ovr_pend <= 1'b0;
                end
            end
            if (rx_ovr) ovr_pend <= 1'b1;
            if (rx_load) begin
                rx_data  <= nine ? rx_sh[7:0] : rx_sh[8:1];
                rx_ninth <= nine ? rx_sh[8] : rx_ninth;
                receive_complete_flag      <= 1'b1;
                fe       <= ~rx_sync;
                or_flag  <= 1'b0;
            end
        end
    end

    // transmitter; once disabled it still sends the character in progress and any buffered one
    wire tx_bit_end = tick16 & (tx_scnt == TICK_LAST);
    wire tx_take    = (tx_st == TX_IDLE) & tx_active & buf_full;
    wire tx_fin     = (tx_st == TX_STOP) & tx_bit_end;
    wire txc_set    = tx_fin & ~(buf_full & tx_active);
    wire next_tx_active = tx_en | (tx_active & ((tx_st != TX_IDLE) | buf_full));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_active <= 1'b0;
        end else begin
            tx_active <= next_tx_active;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_buf   <= 9'h000;
            buf_full <= 1'b0;
        end else begin
            if (tx_take) buf_full <= 1'b0;
            if (wr_data) begin
                tx_buf   <= {ctrl[CTL_TRANSMIT_NINTH_BIT], wb};
                buf_full <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_st   <= TX_IDLE;
            tx_scnt <= 4'h0;
            tx_bcnt <= 4'h0;
            tx_sh   <= 9'h000;
            tx_out  <= 1'b1;
        end else begin
            unique case (tx_st)
                TX_IDLE: begin
                    tx_out  <= 1'b1;
                    tx_scnt <= 4'h0;
                    if (tx_take) begin
                        tx_sh <= tx_buf;
                        tx_st <= TX_START;
                    end
                end
                TX_START: begin
                    tx_out <= 1'b0;
                    if (tick16) tx_scnt <= tx_scnt + 1'b1;
                    if (tx_bit_end) begin
                        tx_bcnt <= 4'h0;
                        tx_st   <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    tx_out <= tx_sh[0];
                    if (tick16) tx_scnt <= tx_scnt + 1'b1;
                    if (tx_bit_end) begin
                        tx_sh   <= {1'b1, tx_sh[8:1]};
                        tx_bcnt <= tx_bcnt + 1'b1;
                        if (tx_bcnt == last_bit) tx_st <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    tx_out <= 1'b1;
                    if (tick16) tx_scnt <= tx_scnt + 1'b1;
                    if (tx_bit_end) tx_st <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            transmit_complete_flag <= 1'b0;
        end else begin
            // set wins over a write-one clear in the same cycle
            transmit_complete_flag <= txc_set | (transmit_complete_flag & ~(wr_stat & wb[ST_TXC]));
        end
    end

    // interrupt events, sticky, write one to clear, set wins
    wire [7:0] ev = {5'b00000, tx_take, txc_set, rx_load};
    wire [7:0] ien = {5'b00000, ctrl[CTL_BUFFER_EMPTY_IRQ_ENABLE], ctrl[CTL_TRANSMIT_COMPLETE_IRQ_ENABLE], ctrl[CTL_RECEIVE_COMPLETE_IRQ_ENABLE]};
    wire [7:0] next_irq_stat = ev | (irq_stat & ~({8{wr_ist}} & wb));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_stat <= 8'h00;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq      <= irq_mask[IRQ_GIE] & |(irq_stat & irq_mask & ien);
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_fe_clear;
        rx_load && rx_sync |=> !fe;
    endproperty
    a_fe_clear: assert property (p_fe_clear) else $error("fe not cleared by good stop");

    property p_overrun;
        rx_done && receive_complete_flag && !data_rd |=> ovr_pend && receive_complete_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not detected");

    property p_or_visible;
        data_rd && ovr_pend && !rx_load |=> or_flag && !ovr_pend;
    endproperty
    a_or_visible: assert property (p_or_visible) else $error("overrun not shown on read");

    property p_or_clear;
        rx_load |=> !or_flag ##0 receive_complete_flag;
    endproperty
    a_or_clear: assert property (p_or_clear) else $error("overrun not cleared on load");

    property p_resv;
        avs_read && !avs_waitrequest && (idx == IDX_STAT) |-> avs_readdata[2:0] == 3'b000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved status bits nonzero");

    property p_irq_rx;
        rx_load && ctrl[CTL_RECEIVE_COMPLETE_IRQ_ENABLE] && irq_mask[IRQ_RX] && irq_mask[IRQ_GIE] && !wr_ctrl && !wr_imsk |=> ##1 irq;
    endproperty
    a_irq_rx: assert property (p_irq_rx) else $error("rx irq missing");

    property p_irq_tx;
        txc_set && ctrl[CTL_TRANSMIT_COMPLETE_IRQ_ENABLE] && irq_mask[IRQ_TX] && irq_mask[IRQ_GIE] && !wr_ctrl && !wr_imsk |=> ##1 irq;
    endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("tx irq missing");

    property p_irq_bufe;
        tx_take && ctrl[CTL_BUFFER_EMPTY_IRQ_ENABLE] && irq_mask[IRQ_BUFE] && irq_mask[IRQ_GIE] && !wr_ctrl && !wr_imsk |=> ##1 irq;
    endproperty
    a_irq_bufe: assert property (p_irq_bufe) else $error("buffer empty irq missing");

    property p_rx_off;
        !rx_en |=> !$rose(receive_complete_flag) && !$rose(fe) && !$rose(ovr_pend);
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx flag set while disabled");

    property p_tx_drain;
        (tx_st != TX_IDLE) |=> tx_active;
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("transmitter stopped mid character");

    property p_tx_idle_high;
        (tx_st == TX_IDLE) [*2] |-> tx_out;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) else $error("line not idle high");

    c_rx_load: cover property (rx_load);
    c_txc: cover property (txc_set ##1 !tx_active);
    c_or: cover property ($rose(or_flag));
endmodule
`default_nettype wire

/* dv/ucsb_remote.sv */
// remote serial device: drives frames into the block and decodes frames from it
// assumes bit_clks system clocks per bit, set by the bench from the divisor
`default_nettype none
module ucsb_remote (
    input  wire logic        sys_clk,
    input  wire logic [11:0] bit_clks,
    input  wire logic        nine,
    input  wire logic        line_in,
    output var  logic        line_out,
    output var  logic        got_valid,
    output var  logic [8:0]  got_data,
    output var  logic        got_stop
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] sh;
    initial begin
        line_out = 1'b1;
        got_valid = 1'b0;
        got_data = 9'h000;
        got_stop = 1'b0;
    end
    // a bad stop is cut short so its tail cannot pass for a new start
    task automatic send(input logic [8:0] d, input logic stp);
        line_out <= 1'b0;
        repeat (bit_clks) @(posedge sys_clk);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            line_out <= d[i];
            repeat (bit_clks) @(posedge sys_clk);
        end
        line_out <= stp;
        repeat (stp ? bit_clks : bit_clks * 5 / 8) @(posedge sys_clk);
        line_out <= 1'b1;
        repeat (bit_clks) @(posedge sys_clk);
    endtask
    // samples at mid-bit; a wrong bit rate shows up as wrong data
    always begin
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge sys_clk);
        if (line_in === 1'b0) begin
            sh = 9'h000;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (bit_clks) @(posedge sys_clk);
                sh[i] = line_in;
            end
            repeat (bit_clks) @(posedge sys_clk);
            got_data <= sh;
            got_stop <= line_in;
            got_valid <= 1'b1;
            @(posedge sys_clk);
            got_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* dv/ucsb_top_tb.sv */
// self-checking bench for the serial control/status/baud block
// assumes the remote line model ucsb_remote on the serial pins
`default_nettype none
module ucsb_top_tb
    import ucsb_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [7:0] e;
        logic [7:0] m;
    } ucsb_exp_t;
    localparam logic [7:0] A_BAUD = {IDX_BAUD, 2'b00};
    localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
    localparam logic [7:0] A_DATA = {IDX_DATA, 2'b00};
    localparam logic [7:0] A_IST  = {IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rx_in;
    logic        tx_out;
    logic        irq;
    logic        nine = 1'b0;
    logic [11:0] bit_clks = 12'h1A0;
    logic        got_valid;
    logic        got_stop;
    logic [8:0]  got_data;
    int          n_fail = 0;
    int          comparisons = 0;
    ucsb_exp_t   rq[$];
    logic [9:0]  txq[$];

    always #12.5 sys_clk = ~sys_clk;

    ucsb_top u_ucsb_top (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rx_in          (rx_in),
        .tx_out         (tx_out),
        .irq            (irq)
    );
    ucsb_remote u_ucsb_remote (
        .sys_clk  (sys_clk),
        .bit_clks (bit_clks),
        .nine     (nine),
        .line_in  (tx_out),
        .line_out (rx_in),
        .got_valid(got_valid),
        .got_data (got_data),
        .got_stop (got_stop)
    );

    task automatic results();
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic hang();
        cmp("wait", 32'h0000_0001, 32'h0000_0000);
        results();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= 32'(d);
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) hang();
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [31:0] q;
        rq.push_back({e, m});
        bus(1'b0, a, 8'h00, q);
    endtask
    task automatic wait_rxc();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, A_STAT, 8'h00, q);
            n++;
        end while (q[ST_RXC] !== 1'b1 && n < 400);
        if (q[ST_RXC] !== 1'b1) hang();
    endtask
    task automatic wait_q();
        int n;
        n = 0;
        while (txq.size() > 0 && n < 6000) begin
            @(posedge sys_clk);
            n++;
        end
        if (txq.size() > 0) hang();
        // the model reports from the stop centre; let the stop bit and drain finish
        repeat (bit_clks) @(posedge sys_clk);
    endtask
    // irq is registered, so give it a few edges before looking
    task automatic irq_is(input logic v);
        int n;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while (irq !== v && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        cmp("irq", 32'(v), 32'(irq));
    endtask

    always @(posedge sys_clk) begin
        ucsb_exp_t x;
        logic [9:0] y;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0) begin
            x = rq.pop_front();
            cmp("read", 32'(x.e & x.m), avs_readdata & {24'hFF_FFFF, x.m});
        end
        if (got_valid === 1'b1) begin
            y = 'x;
            if (txq.size() > 0) y = txq.pop_front();
            cmp("line", 32'(y), 32'({got_stop, got_data}));
        end
    end

    initial begin
        logic [7:0] r;
        logic [7:0] r2;
        void'($urandom(16991));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rd(A_CTRL, CTRL_RST, 8'hFF);
        rd(A_BAUD, BAUD_RST, 8'hFF);
        rd(A_STAT, 8'h20, 8'hFF);
        rd(A_MASK, MASK_RST, 8'hFF);
        rd(8'hFC, 8'h00, 8'hFF);
        r = 8'($urandom);
        wr(A_BAUD, r);
        rd(A_BAUD, r, 8'hFF);
        avs_byteenable <= 4'h0;
        wr(A_BAUD, ~r);
        avs_byteenable <= 4'hF;
        rd(A_BAUD, r, 8'hFF);
        wr(A_BAUD, 8'h19);
        wr(A_CTRL, 8'h08);
        r = 8'($urandom);
        txq.push_back({2'b10, r});
        wr(A_DATA, r);
        wait_q();
        bit_clks <= 12'h020;
        wr(A_BAUD, 8'h01);
        rd(A_STAT, 8'h60, 8'hFF);
        wr(A_STAT, 8'h40);
        rd(A_STAT, 8'h20, 8'hFF);
        for (int k = 0; k < 2; k++) begin
            r = 8'($urandom);
            txq.push_back({2'b10, r});
            wr(A_DATA, r);
        end
        wr(A_CTRL, 8'h00);
        wait_q();
        r = 8'($urandom);
        wr(A_DATA, r);
        repeat (800) @(posedge sys_clk);
        txq.push_back({2'b10, r});
        wr(A_CTRL, 8'h08);
        wait_q();
        nine <= 1'b1;
        wr(A_CTRL, 8'h0D);
        r = 8'($urandom);
        txq.push_back({2'b11, r});
        wr(A_DATA, r);
        wait_q();
        rd(A_CTRL, 8'h0C, 8'hFD);
        nine <= 1'b0;
        wr(A_CTRL, 8'h00);
        u_ucsb_remote.send(9'h0A5, 1'b1);
        rd(A_STAT, 8'h00, 8'h98);
        wr(A_CTRL, 8'h10);
        r = 8'($urandom);
        u_ucsb_remote.send({1'b0, r}, 1'b1);
        wait_rxc();
        rd(A_DATA, r, 8'hFF);
        u_ucsb_remote.send(9'h03C, 1'b0);
        wait_rxc();
        rd(A_STAT, 8'h90, 8'h90);
        rd(A_DATA, 8'h3C, 8'hFF);
        wr(A_CTRL, 8'h00);
        rd(A_STAT, 8'h10, 8'h10);
        wr(A_CTRL, 8'h10);
        r2 = 8'($urandom);
        u_ucsb_remote.send({1'b0, r}, 1'b1);
        u_ucsb_remote.send({1'b0, r2}, 1'b1);
        wait_rxc();
        rd(A_STAT, 8'h80, 8'h98);
        rd(A_DATA, r, 8'hFF);
        rd(A_STAT, 8'h08, 8'h88);
        u_ucsb_remote.send({1'b0, ~r}, 1'b1);
        wait_rxc();
        rd(A_STAT, 8'h80, 8'h98);
        rd(A_DATA, ~r, 8'hFF);
        nine <= 1'b1;
        wr(A_CTRL, 8'h14);
        u_ucsb_remote.send({1'b0, r2}, 1'b1);
        wait_rxc();
        rd(A_CTRL, 8'h14, 8'hFF);
        rd(A_DATA, r2, 8'hFF);
        nine <= 1'b0;
        wr(A_MASK, 8'h81);
        wr(A_CTRL, 8'h90);
        wr(A_IST, 8'h07);
        u_ucsb_remote.send({1'b0, r}, 1'b1);
        wait_rxc();
        irq_is(1'b1);
        rd(A_IST, 8'h01, 8'h01);
        rd(A_DATA, r, 8'hFF);
        wr(A_IST, 8'h01);
        irq_is(1'b0);
        wr(A_MASK, 8'h01);
        u_ucsb_remote.send({1'b0, r2}, 1'b1);
        wait_rxc();
        irq_is(1'b0);
        rd(A_DATA, r2, 8'hFF);
        wr(A_MASK, 8'h82);
        wr(A_CTRL, 8'h48);
        wr(A_IST, 8'h07);
        txq.push_back({2'b10, r});
        wr(A_DATA, r);
        irq_is(1'b0);
        wait_q();
        irq_is(1'b1);
        wr(A_MASK, 8'h84);
        wr(A_CTRL, 8'h28);
        wr(A_IST, 8'h07);
        irq_is(1'b0);
        txq.push_back({2'b10, r2});
        wr(A_DATA, r2);
        irq_is(1'b1);
        wait_q();
        results();
    end
endmodule
`default_nettype wire
